/* File: charger_status_fault_regs.v */
// Control, status and fault register bank of a single-cell charger
`timescale 1ns/10ps
`include "charger_regs_map.vh"

module charger_status_fault_regs (
  input  wire       core_clk_i,                // Core clock, 100 MHz
  input  wire       rst_n_i,                   // Synchronous reset, active low
  // Byte access from the serial interface engine
  input  wire [7:0] reg_addr_i,                // Register address
  input  wire       reg_wr_i,                  // Write strobe
  input  wire [7:0] reg_wdata_i,               // Write data
  input  wire       reg_rd_i,                  // Single-byte read strobe
  output reg  [7:0] reg_rdata_o,               // Read data
  output reg        reg_rvalid_o,              // Read data valid pulse
  // Input detection
  input  wire       input_present_i,           // Input supply present
  input  wire       detect_done_i,             // Detection run finished pulse
  output reg        force_input_limit_detect_o, // Detection run request
  // Safety timer
  input  wire       timer_tick_i,              // Base timer tick pulse
  output reg        timer_step_o,              // Safety timer advance pulse
  // Battery path switch
  output reg        battery_switch_off_o,      // Battery path switch forced off
  // Status levels
  input  wire [1:0] input_source_status_i,     // Detected source type
  input  wire [1:0] charge_phase_status_i,     // Charge phase
  input  wire       input_voltage_limiting_i,  // Input voltage limit active
  input  wire       input_current_limiting_i,  // Input current limit active
  input  wire       input_good_status_i,       // Input qualified good
  input  wire       thermal_reg_status_i,      // Thermal regulation active
  input  wire       sys_min_reg_status_i,      // Minimum system voltage regulation
  // Fault levels
  input  wire       watchdog_expired_i,        // Host watchdog expired
  input  wire       boost_fault_i,             // Boost blocked or stopped
  input  wire [1:0] charge_fault_code_i,       // Present charge fault code
  input  wire       battery_overvoltage_fault_i, // Battery overvoltage
  input  wire       boost_mode_i,              // Boost mode selects thermistor thresholds
  input  wire       cold_charge_i,             // Cold against charging threshold
  input  wire       hot_charge_i,              // Hot against charging threshold
  input  wire       cold_boost_i,              // Cold against boost threshold
  input  wire       hot_boost_i,               // Hot against boost threshold
  // Host notification
  output reg        int_o                      // Fault interrupt pulse
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [7:0] ctrl_q;
  reg  [7:0] ctrl_d;
  reg  [7:0] status_q;
  reg  [7:0] status_d;
  reg        detect_q;
  reg        detect_d;
  reg        half_q;
  reg        adapter_q;
  reg  [7:0] rdata_d;
  wire       ctrl_wr;
  wire       fault_rd;
  wire       slow_timer;
  wire       adapter_gone;
  wire       cold_sel;
  wire       hot_sel;
  wire [7:0] fault_byte;
  wire       new_fault;
  wire [1:0] therm_charge;
  wire [1:0] therm_boost;
  wire [1:0] therm_sel;
  genvar     g;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Writes land only on the control register
  assign ctrl_wr  = reg_wr_i & (reg_addr_i == `MISC_OPERATION_CONTROL_ADDR);
  // Each single-byte read of the fault register clears it
  assign fault_rd = reg_rd_i & (reg_addr_i == `LATCHED_FAULT_ADDR);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Plain storage for timer, switch, reserved and mask bits
  always @*
  begin
    ctrl_d = ctrl_q;
    if (ctrl_wr)
    begin
      ctrl_d = reg_wdata_i;
    end
    // Trigger bit mirrors the detection state
    ctrl_d[`CTRL_FORCE_DETECT_BIT] = detect_d;
  end

  // Control flops, masks and slowdown set out of reset
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= `MISC_OPERATION_CONTROL_RST;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------
  // Forced input limit detection
  // ----------------------------------------
  // Request set by write with input present, cleared when run ends;
  // a new trigger in the finishing cycle wins over the clear
  always @*
  begin
    detect_d = detect_q;
    if (detect_q && detect_done_i)
    begin
      detect_d = 1'b0;
    end
    if (!input_present_i)
    begin
      detect_d = 1'b0;
    end
    if (ctrl_wr && reg_wdata_i[`CTRL_FORCE_DETECT_BIT] && input_present_i)
    begin
      detect_d = 1'b1;
    end
  end

  // Request flop and its pin copy
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      detect_q                   <= 1'b0;
      force_input_limit_detect_o <= 1'b0;
    end
    else
    begin
      detect_q                   <= detect_d;
      force_input_limit_detect_o <= detect_d;
    end
  end

  // ----------------------------------------
  // Safety timer speed
  // ----------------------------------------
  // Slowed only while limiting or regulating thermally
  assign slow_timer = ctrl_q[`CTRL_TIMER_HALF_BIT] &
                      (input_voltage_limiting_i | input_current_limiting_i |
                       thermal_reg_status_i);

  // Half speed passes every second tick
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      half_q       <= 1'b0;
      timer_step_o <= 1'b0;
    end
    else
    begin
      if (timer_tick_i)
      begin
        half_q <= slow_timer ? ~half_q : 1'b0;
      end
      timer_step_o <= timer_tick_i & (~slow_timer | half_q);
    end
  end

  // ----------------------------------------
  // Battery path switch
  // ----------------------------------------
  // Follows the control value in the write's cycle
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      battery_switch_off_o <= 1'b0;
    end
    else
    begin
      battery_switch_off_o <= ctrl_d[`CTRL_SWITCH_OFF_BIT];
    end
  end

  // ----------------------------------------
  // System status register
  // ----------------------------------------
  // Sampled every cycle from the charger's live state
  always @*
  begin
    status_d = {input_source_status_i,
                charge_phase_status_i,
                input_voltage_limiting_i | input_current_limiting_i,
                input_good_status_i,
                thermal_reg_status_i,
                sys_min_reg_status_i};
  end

  // Status snapshot, one cycle behind the inputs
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      status_q <= 8'h00;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------
  // Adapter removal detect
  // ----------------------------------------
  // One pulse on the adapter-to-other transition
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      adapter_q <= 1'b0;
    end
    else
    begin
      adapter_q <= (input_source_status_i == `SOURCE_ADAPTER);
    end
  end

  // Single pulse as the adapter leaves
  assign adapter_gone = adapter_q & (input_source_status_i != `SOURCE_ADAPTER);

  // ----------------------------------------
  // Thermistor threshold selection
  // ----------------------------------------
  // Bit 1 cold, bit 0 hot; boost mode uses its own comparator pair
  assign therm_charge = {cold_charge_i, hot_charge_i};
  assign therm_boost  = {cold_boost_i, hot_boost_i};

  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_therm_sel
      assign therm_sel[g] = boost_mode_i ? therm_boost[g] : therm_charge[g];
    end
  endgenerate

  assign cold_sel = therm_sel[1];
  assign hot_sel  = therm_sel[0];

  // ----------------------------------------
  // Latched fault register
  // ----------------------------------------
  fault_latch u_fault_latch (
    .core_clk_i     (core_clk_i),
    .rst_n_i        (rst_n_i),
    .watchdog_i     (watchdog_expired_i),
    .boost_i        (boost_fault_i),
    .charge_code_i  (charge_fault_code_i),
    .adapter_gone_i (adapter_gone),
    .battery_ov_i   (battery_overvoltage_fault_i),
    .cold_i         (cold_sel),
    .hot_i          (hot_sel),
    .read_clear_i   (fault_rd),
    .mask_charge_i  (ctrl_q[`CTRL_MASK_CHARGE_BIT]),
    .mask_battery_i (ctrl_q[`CTRL_MASK_BATTERY_BIT]),
    .fault_q        (fault_byte),
    .new_fault_q    (new_fault)
  );

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Fault pulse moved onto a pin flop
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      int_o <= 1'b0;
    end
    else
    begin
      int_o <= new_fault;
    end
  end

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  // Unmapped addresses read as zero
  always @*
  begin
    case (reg_addr_i)
      `MISC_OPERATION_CONTROL_ADDR: rdata_d = ctrl_q;
      `SYSTEM_STATUS_ADDR:          rdata_d = status_q;
      `LATCHED_FAULT_ADDR:          rdata_d = fault_byte;
      default:                      rdata_d = `UNMAPPED_READ_VALUE;
    endcase
  end

  // Data held until the next read
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

endmodule // charger_status_fault_regs

/* File: charger_regs_map.vh */
// Register offsets, field positions, reset values and codes of the charger register bank
`ifndef CHARGER_REGS_MAP_VH
`define CHARGER_REGS_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MISC_OPERATION_CONTROL_ADDR 8'h07
`define SYSTEM_STATUS_ADDR          8'h08
`define LATCHED_FAULT_ADDR          8'h09

// ----------------------------------------
// Reset and read values
// ----------------------------------------
`define MISC_OPERATION_CONTROL_RST  8'h4b
`define UNMAPPED_READ_VALUE         8'h00

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_FORCE_DETECT_BIT       7
`define CTRL_TIMER_HALF_BIT         6
`define CTRL_SWITCH_OFF_BIT         5
`define CTRL_MASK_CHARGE_BIT        1
`define CTRL_MASK_BATTERY_BIT       0

// ----------------------------------------
// Fault register fields
// ----------------------------------------
`define FAULT_WATCHDOG_BIT          7
`define FAULT_BOOST_BIT             6
`define FAULT_CHARGE_HI             5
`define FAULT_CHARGE_LO             4
`define FAULT_BATTERY_BIT           3
`define FAULT_RESERVED_BIT          2
`define FAULT_COLD_BIT              1
`define FAULT_HOT_BIT               0

// ----------------------------------------
// Field codes
// ----------------------------------------
`define SOURCE_NONE                 2'h0
`define SOURCE_USB_HOST             2'h1
`define SOURCE_ADAPTER              2'h2
`define SOURCE_BOOST                2'h3
`define CHARGE_FAULT_NORMAL         2'h0
`define CHARGE_FAULT_INPUT          2'h1
`define CHARGE_FAULT_THERMAL        2'h2
`define CHARGE_FAULT_TIMER          2'h3

`endif

/* File: fault_latch.v */
// Sticky fault register with clear on read and fault event pulse
`timescale 1ns/10ps
`include "charger_regs_map.vh"

module fault_latch (
  input  wire       core_clk_i,      // Core clock
  input  wire       rst_n_i,         // Synchronous reset, active low
  input  wire       watchdog_i,      // Watchdog expired level
  input  wire       boost_i,         // Boost blocked level
  input  wire [1:0] charge_code_i,   // Present charge fault code
  input  wire       adapter_gone_i,  // Adapter removal pulse
  input  wire       battery_ov_i,    // Battery overvoltage level
  input  wire       cold_i,          // Thermistor cold level
  input  wire       hot_i,           // Thermistor hot level
  input  wire       read_clear_i,    // Fault register read pulse
  input  wire       mask_charge_i,   // Charge fault interrupt enable
  input  wire       mask_battery_i,  // Battery fault interrupt enable
  output reg  [7:0] fault_q,         // Latched fault byte
  output reg        new_fault_q      // New unmasked fault pulse
);

  reg  [7:0] event_d;
  reg  [7:0] fault_d;
  reg  [1:0] code_d;
  reg  [7:0] rise_d;

  // ----------------------------------------
  // Next fault byte
  // ----------------------------------------
  // Read returns then clears; events this cycle survive the clear
  always @*
  begin
    code_d = adapter_gone_i ? `CHARGE_FAULT_INPUT : charge_code_i;
    event_d = 8'h00;
    event_d[`FAULT_WATCHDOG_BIT] = watchdog_i;
    event_d[`FAULT_BOOST_BIT] = boost_i;
    event_d[`FAULT_CHARGE_HI:`FAULT_CHARGE_LO] = code_d;
    event_d[`FAULT_BATTERY_BIT] = battery_ov_i;
    event_d[`FAULT_COLD_BIT] = cold_i;
    event_d[`FAULT_HOT_BIT] = hot_i;
    fault_d = read_clear_i ? 8'h00 : fault_q;
    fault_d = fault_d | {event_d[7:6], 2'b00, event_d[3:0]};
    // First code held until read
    if (fault_d[`FAULT_CHARGE_HI:`FAULT_CHARGE_LO] == `CHARGE_FAULT_NORMAL)
    begin
      fault_d[`FAULT_CHARGE_HI:`FAULT_CHARGE_LO] = code_d;
    end
    fault_d[`FAULT_RESERVED_BIT] = 1'b0;
    rise_d = fault_d & ~fault_q;
  end

  // ----------------------------------------
  // Fault and event registers
  // ----------------------------------------
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      fault_q     <= 8'h00;
      new_fault_q <= 1'b0;
    end
    else
    begin
      fault_q     <= fault_d;
      new_fault_q <= rise_d[`FAULT_WATCHDOG_BIT] | rise_d[`FAULT_BOOST_BIT] |
                     ((rise_d[`FAULT_CHARGE_HI] | rise_d[`FAULT_CHARGE_LO]) & mask_charge_i) |
                     (rise_d[`FAULT_BATTERY_BIT] & mask_battery_i) |
                     rise_d[`FAULT_COLD_BIT] | rise_d[`FAULT_HOT_BIT];
    end
  end

endmodule // fault_latch

/* File: regs_properties.sv */
// Concurrent checks on the charger register bank ports
`timescale 1ns/10ps
module regs_properties (
  input logic       core_clk_i,                  // Clock
  input logic       rst_n_i,                     // Reset, low
  input logic [7:0] reg_addr_i,                  // Address
  input logic       reg_wr_i,                    // Write strobe
  input logic [7:0] reg_wdata_i,                 // Write data
  input logic       reg_rd_i,                    // Read strobe
  input logic [7:0] reg_rdata_o,                 // Read data
  input logic       reg_rvalid_o,                // Read valid
  input logic       input_present_i,             // Supply present
  input logic       detect_done_i,               // Detection done
  input logic       force_input_limit_detect_o,  // Detection request
  input logic       timer_tick_i,                // Base tick
  input logic       timer_step_o,                // Timer step
  input logic       battery_switch_off_o,        // Switch off
  input logic       input_voltage_limiting_i,    // Voltage limit
  input logic       input_current_limiting_i,    // Current limit
  input logic       thermal_reg_status_i,        // Thermal regulation
  input logic       watchdog_expired_i,          // Watchdog
  input logic       battery_overvoltage_fault_i  // Battery overvoltage
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // --------------------------------------
  // Decodes
  // --------------------------------------
  // Strobe decodes and slowdown condition
  wire wr7 = reg_wr_i && (reg_addr_i == 8'h07);
  wire rd9 = reg_rd_i && (reg_addr_i == 8'h09);
  wire set7 = wr7 && reg_wdata_i[7];
  wire calm = !input_voltage_limiting_i && !input_current_limiting_i && !thermal_reg_status_i;
  wire frc = force_input_limit_detect_o;
  // --------------------------------------
  // Properties
  // --------------------------------------
  switch_follow_a: assert property (wr7 |=> battery_switch_off_o == $past(reg_wdata_i[5]))
    else $error("switch output differs from written bit");
  detect_start_a: assert property (set7 && input_present_i |=> frc)
    else $error("detection not started");
  detect_absent_a: assert property (!input_present_i |=> !frc)
    else $error("detection request without supply");
  detect_hold_a: assert property (frc && input_present_i && !detect_done_i && !wr7 |=> frc)
    else $error("detection request dropped early");
  detect_clear_a: assert property (detect_done_i && !set7 |=> !frc)
    else $error("detection request not cleared");
  step_cause_a: assert property (timer_step_o |-> $past(timer_tick_i))
    else $error("timer step without tick");
  step_normal_a: assert property (timer_tick_i && calm |=> timer_step_o)
    else $error("tick dropped at normal speed");
  watchdog_latch_a: assert property (watchdog_expired_i ##1 rd9 |=> reg_rdata_o[7])
    else $error("watchdog fault not latched");
  battery_latch_a: assert property (battery_overvoltage_fault_i ##1 rd9 |=> reg_rdata_o[3])
    else $error("battery fault not latched");
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o) && !reg_rvalid_o)
    else $error("read data moved without read");
  // Main scenarios reached
  fault_read_c: cover property (rd9 ##1 reg_rvalid_o);
  detect_run_c: cover property (set7 ##1 frc ##[1:20] !frc);
  slow_tick_c: cover property (timer_tick_i && !calm);
endmodule // regs_properties

bind charger_status_fault_regs regs_properties chk (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
  .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .input_present_i, .detect_done_i,
  .force_input_limit_detect_o, .timer_tick_i, .timer_step_o, .battery_switch_off_o,
  .input_voltage_limiting_i, .input_current_limiting_i, .thermal_reg_status_i,
  .watchdog_expired_i, .battery_overvoltage_fault_i);

/* File: host_model.sv */
// Host side model issuing single-byte register accesses
`timescale 1ns/10ps
module host_model (
  input  wire       core_clk_i,    // Clock
  input  wire [7:0] reg_rdata_o,   // Read data
  input  wire       reg_rvalid_o,  // Read valid
  output reg  [7:0] reg_addr_i,    // Address
  output reg        reg_wr_i,      // Write strobe
  output reg  [7:0] reg_wdata_i,   // Write data
  output reg        reg_rd_i       // Read strobe
);
  // Idle bus at start
  initial
  begin
    reg_addr_i = 8'hff;
    reg_wr_i = 1'b0;
    reg_wdata_i = 8'h00;
    reg_rd_i = 1'b0;
  end
  // One write strobe, then released lines show the inverse
  task wr_reg(input [7:0] a, input [7:0] d);
  begin
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    reg_addr_i = ~a;
    reg_wdata_i = ~d;
  end
  endtask
  // One single-byte read, never a burst; a missing answer gives unknown
  task rd_reg(input [7:0] a, output [7:0] d);
  begin
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    reg_addr_i = ~a;
    d = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 8'hxx;
  end
  endtask
endmodule // host_model

/* File: testbench.sv */
// Self-checking bench for the charger register bank
`timescale 1ns/10ps
module testbench;
  reg        clk;
  reg        rst_n;
  reg  [7:0] flt;    // Fault levels
  reg  [3:0] thm;    // Thermistor levels
  reg  [8:0] st;     // Status levels
  reg        pres;
  reg        done;
  reg        tick;
  reg        bmode;
  reg  [31:0] seed;
  reg  [7:0] v;
  reg  [7:0] w;
  integer    mismatches;
  integer    checks_done;
  integer    ints;
  integer    steps;
  integer    i;
  wire [7:0] addr;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire       wr;
  wire       rd;
  wire       rvalid;
  wire       frc;
  wire       step;
  wire       swoff;
  wire       intr;
  // --------------------------------------
  // Design and host
  // --------------------------------------
  charger_status_fault_regs uut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .input_present_i(pres), .detect_done_i(done), .force_input_limit_detect_o(frc),
    .timer_tick_i(tick), .timer_step_o(step), .battery_switch_off_o(swoff),
    .input_source_status_i(st[8:7]), .charge_phase_status_i(st[6:5]), .input_voltage_limiting_i(st[4]),
    .input_current_limiting_i(st[3]), .input_good_status_i(st[2]), .thermal_reg_status_i(st[1]),
    .sys_min_reg_status_i(st[0]), .watchdog_expired_i(flt[7]), .boost_fault_i(flt[6]),
    .charge_fault_code_i(flt[5:4]), .battery_overvoltage_fault_i(flt[3]), .boost_mode_i(bmode),
    .cold_charge_i(thm[3]), .hot_charge_i(thm[2]), .cold_boost_i(thm[1]), .hot_boost_i(thm[0]),
    .int_o(intr));
  host_model host (.core_clk_i(clk), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd));
  // Clock and pulse counters, sampled mid-cycle
  always #5 clk = ~clk;
  always @(negedge clk)
  begin
    ints = ints + (intr === 1'b1);
    steps = steps + (step === 1'b1);
  end
  // --------------------------------------
  // Helpers
  // --------------------------------------
  function [31:0] rnd(input [31:0] r);
    rnd = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  function [7:0] st_exp(input [8:0] s);
    st_exp = {s[8:5], s[4] | s[3], s[2:0]};
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task rdc(input [7:0] a, input [7:0] e);
  begin
    host.rd_reg(a, v);
    chk(v, e);
  end
  endtask
  // Pulse one fault, count interrupts, read twice
  task fcase(input [7:0] f, input [3:0] t, input m, input [7:0] e, input [7:0] n);
  begin
    bmode = m;
    cyc(2);
    ints = 0;
    flt = f;
    thm = t;
    cyc(1);
    flt = 8'h00;
    thm = 4'h0;
    cyc(4);
    chk(ints[7:0], n);
    rdc(8'h09, e);
    rdc(8'h09, 8'h00);
  end
  endtask
  // Four ticks, expected step count
  task timer_run(input [7:0] n);
  begin
    steps = 0;
    repeat (4)
    begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(2);
    end
    chk(steps[7:0], n);
  end
  endtask
  task end_of_test;
  begin
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // --------------------------------------
  // Main sequence
  // --------------------------------------
  initial
  begin
    clk = 0; rst_n = 0; flt = 0; thm = 0; st = 0; pres = 1; done = 0; tick = 0; bmode = 0;
    mismatches = 0; checks_done = 0; ints = 0; steps = 0; seed = 32'had9e910e;
    cyc(10);
    rst_n = 1;
    cyc(3);
    rdc(8'h07, 8'h4b);
    rdc(8'h09, 8'h00);
    rdc(8'h2a, 8'h00);
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1)
    begin
      seed = rnd(seed);
      w = seed[7:0] | 8'h80;
      pres = seed[8] | (i == 0);
      host.wr_reg(8'h07, w);
      chk({7'h00, frc}, {7'h00, pres});
      chk({7'h00, swoff}, {7'h00, w[5]});
      done = 1'b1;
      cyc(1);
      done = 1'b0;
      rdc(8'h07, {1'b0, w[6:0]});
    end
    pres = 1'b1;
    host.wr_reg(8'h07, 8'h4b);
    $display("control test done");
    for (i = 0; i < 8; i = i + 1)
    begin
      seed = rnd(seed);
      st = {i[1:0], i[2:1], seed[4:0]};
      cyc(3);
      rdc(8'h08, st_exp(st));
    end
    st = 0;
    cyc(3);
    host.rd_reg(8'h09, v);
    host.rd_reg(8'h09, v);
    $display("status test done");
    fcase(8'h80, 4'h0, 1'b0, 8'h80, 8'h01);
    fcase(8'h40, 4'h0, 1'b0, 8'h40, 8'h01);
    for (i = 1; i < 4; i = i + 1)
      fcase({2'h0, i[1:0], 4'h0}, 4'h0, 1'b0, {2'h0, i[1:0], 4'h0}, 8'h01);
    fcase(8'h08, 4'h0, 1'b0, 8'h08, 8'h01);
    for (i = 0; i < 8; i = i + 1)
    begin
      // Fault only when the pulsed comparator suits the mode; thermistor faults always interrupt
      w = (i[1] != i[2]) ? {6'h00, 2'h1 << i[0]} : 8'h00;
      fcase(8'h00, 4'h1 << i[1:0], i[2], w, {7'h00, i[1] != i[2]});
    end
    flt = 8'h88;
    cyc(2);
    rdc(8'h09, 8'h88);
    rdc(8'h09, 8'h88);
    flt = 8'h00;
    cyc(2);
    rdc(8'h09, 8'h88);
    rdc(8'h09, 8'h00);
    host.wr_reg(8'h07, 8'h48);
    fcase(8'h10, 4'h0, 1'b0, 8'h10, 8'h00);
    fcase(8'h08, 4'h0, 1'b0, 8'h08, 8'h00);
    host.wr_reg(8'h07, 8'h4b);
    st = 9'h100;
    cyc(3);
    st = 9'h000;
    cyc(3);
    rdc(8'h09, 8'h10);
    rdc(8'h09, 8'h00);
    $display("fault test done");
    st = 9'h002;
    timer_run(8'h02);
    st = 9'h010;
    timer_run(8'h02);
    st = 9'h000;
    timer_run(8'h04);
    host.wr_reg(8'h07, 8'h0b);
    st = 9'h002;
    timer_run(8'h04);
    $display("timer test done");
    end_of_test;
  end
endmodule // testbench
